// [hw/pif_irq_ctrl.v]
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "pif_consts.vh"

module pif_irq_ctrl (
  input wire ref_clk,
  input wire sys_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // core flag events: timer0, external pin, port-b change (one-cycle pulses)
  input wire [2:0] core_event,
  // peripheral events, bit order of peripheral_flags_one
  input wire [7:0] periph_event,
  input wire capture_event,
  input wire compare_event,
  input wire [1:0] capcomp_two_mode,
  // portb change flag value at power-up is unknown; taken from a pin
  input wire portb_change_async,
  // processor core handshake
  input wire irq_accept,
  input wire [12:0] return_pc,
  output reg core_irq_req_q,
  output reg push_return_q,
  output reg [12:0] pushed_pc_q,
  output reg load_vector_q,
  output reg [12:0] vector_pc_q,
  output reg global_irq_enable_q,
  output reg [7:0] option_q,
  output reg irq_q
);

  // ************************************
  // register state
  // ************************************
  reg [7:0] enables_one_q;
  reg capcomp_two_enable_q;
  reg global_en_q;
  reg periph_group_en_q;
  reg [2:0] core_en_q;
  reg [2:0] irq_status_q;
  reg [2:0] irq_mask_q;
  reg req_prev_q;

  wire [2:0] core_flags;
  wire [7:0] flags_one;
  wire capcomp_two_flag;
  wire portb_sync;

  // ************************************
  // bus decode
  // ************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire bus_rd = bus_req & ~wb_we_i;
  wire hit_core = (wb_adr_i == `PIF_ADDR_CORE_CTRL);
  wire hit_opt = (wb_adr_i == `PIF_ADDR_OPTION);
  wire hit_f1 = (wb_adr_i == `PIF_ADDR_FLAGS_ONE);
  wire hit_f2 = (wb_adr_i == `PIF_ADDR_FLAGS_TWO);
  wire hit_e1 = (wb_adr_i == `PIF_ADDR_ENABLES_ONE);
  wire hit_e2 = (wb_adr_i == `PIF_ADDR_ENABLES_TWO);
  wire hit_st = (wb_adr_i == `PIF_ADDR_IRQ_STATUS);
  wire hit_mk = (wb_adr_i == `PIF_ADDR_IRQ_MASK);
  wire hit_vec = (wb_adr_i == `PIF_ADDR_VECTOR);
  wire hit_any = hit_core | hit_opt | hit_f1 | hit_f2 | hit_e1 | hit_e2 | hit_st
    | hit_mk | hit_vec;

  // ************************************
  // flags
  // ************************************
  pif_sync2 u_portb_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(portb_change_async),
    .sync_q(portb_sync)
  );

  // the synchroniser needs two edges before it shows the pin, so the
  // power-up portb change value is taken on the third edge after reset
  reg [1:0] boot_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_q <= 2'h0;
    end else if (boot_q != 2'h3) begin
      boot_q <= boot_q + 2'h1;
    end
  end

  wire boot_take = (boot_q == 2'h2);
  wire [2:0] core_set = {core_event[2:1], core_event[0] | (boot_take & portb_sync)};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_core_flag
      pif_flag_bit u_flag (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_in(core_set[gi]),
        .wr_en(bus_wr & hit_core),
        .wr_val(wb_dat_i[gi]),
        .flag_q(core_flags[gi])
      );
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_periph_flag
      pif_flag_bit u_flag (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_in(periph_event[gi]),
        .wr_en(bus_wr & hit_f1),
        .wr_val(wb_dat_i[gi]),
        .flag_q(flags_one[gi])
      );
    end
  endgenerate

  // capture sets in capture mode, match in compare mode, nothing in pwm
  wire capcomp_two_set = ((capcomp_two_mode == `PIF_MODE_CAPTURE) & capture_event)
    | ((capcomp_two_mode == `PIF_MODE_COMPARE) & compare_event);

  pif_flag_bit u_capcomp_two (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .set_in(capcomp_two_set),
    .wr_en(bus_wr & hit_f2),
    .wr_val(wb_dat_i[`PIF_BIT_CAPCOMP_TWO]),
    .flag_q(capcomp_two_flag)
  );

  // ************************************
  // request logic
  // ************************************
  // a flag left pending when its enable is set requests at once: clear it first
  wire core_pending = |(core_flags & core_en_q);
  wire periph_pending = |(flags_one & enables_one_q)
    | (capcomp_two_flag & capcomp_two_enable_q);
  wire req_d = global_en_q & (core_pending | (periph_group_en_q & periph_pending));
  wire accept = irq_accept & core_irq_req_q & global_en_q;

  // ************************************
  // control registers and bus
  // ************************************
  wire [7:0] core_rd = {global_en_q, periph_group_en_q, core_en_q, core_flags};
  wire [2:0] ev_set = {capcomp_two_set, accept, req_d & ~req_prev_q};

  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (1'b1)
      hit_core: rd_mux = core_rd;
      hit_opt: rd_mux = option_q;
      hit_f1: rd_mux = flags_one;
      hit_f2: rd_mux = {7'h00, capcomp_two_flag};
      hit_e1: rd_mux = enables_one_q;
      hit_e2: rd_mux = {7'h00, capcomp_two_enable_q};
      hit_st: rd_mux = {5'h00, irq_status_q};
      hit_mk: rd_mux = {5'h00, irq_mask_q};
      hit_vec: rd_mux = vector_pc_q[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      global_en_q <= 1'b0;
      periph_group_en_q <= 1'b0;
      core_en_q <= 3'h0;
      option_q <= `PIF_RST_OPTION;
      enables_one_q <= `PIF_RST_ENABLES_ONE;
      capcomp_two_enable_q <= 1'b0;
      irq_mask_q <= `PIF_RST_MASK;
      irq_status_q <= 3'h0;
      irq_q <= 1'b0;
      req_prev_q <= 1'b0;
      core_irq_req_q <= 1'b0;
      push_return_q <= 1'b0;
      load_vector_q <= 1'b0;
      pushed_pc_q <= 13'h0000;
      vector_pc_q <= 13'h0000;
      global_irq_enable_q <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & hit_any;
      wb_err_o <= bus_req & ~hit_any;
      wb_dat_o <= (bus_rd & hit_any) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      if (bus_wr & hit_core) begin
        global_en_q <= wb_dat_i[`PIF_BIT_GLOBAL_EN];
        periph_group_en_q <= wb_dat_i[`PIF_BIT_PERIPH_EN];
        core_en_q <= wb_dat_i[`PIF_CORE_EN_HI:`PIF_CORE_EN_LO];
      end else if (accept) begin
        // entering service masks further requests
        global_en_q <= 1'b0;
      end
      if (bus_wr & hit_opt) begin
        option_q <= wb_dat_i[7:0];
      end
      if (bus_wr & hit_e1) begin
        enables_one_q <= wb_dat_i[7:0];
      end
      if (bus_wr & hit_e2) begin
        capcomp_two_enable_q <= wb_dat_i[`PIF_BIT_CAPCOMP_TWO];
      end
      if (bus_wr & hit_mk) begin
        irq_mask_q <= wb_dat_i[2:0];
      end
      // read clears status, new events win
      if (bus_rd & hit_st) begin
        irq_status_q <= ev_set;
      end else begin
        irq_status_q <= irq_status_q | ev_set;
      end
      irq_q <= |(irq_status_q & irq_mask_q);
      req_prev_q <= req_d;
      core_irq_req_q <= req_d;
      push_return_q <= accept;
      load_vector_q <= accept;
      if (accept) begin
        pushed_pc_q <= return_pc;
        vector_pc_q <= `PIF_VECTOR;
      end
      global_irq_enable_q <= (bus_wr & hit_core) ? wb_dat_i[`PIF_BIT_GLOBAL_EN]
        : (accept ? 1'b0 : global_en_q);
    end
  end

endmodule // pif_irq_ctrl

// [hw/pif_consts.vh]
`ifndef PIF_CONSTS_VH
`define PIF_CONSTS_VH

// ************************************
// register byte addresses
// ************************************
`define PIF_ADDR_CORE_CTRL 8'h00
`define PIF_ADDR_OPTION 8'h04
`define PIF_ADDR_FLAGS_ONE 8'h08
`define PIF_ADDR_FLAGS_TWO 8'h0c
`define PIF_ADDR_ENABLES_ONE 8'h10
`define PIF_ADDR_ENABLES_TWO 8'h14
`define PIF_ADDR_IRQ_STATUS 8'h18
`define PIF_ADDR_IRQ_MASK 8'h1c
`define PIF_ADDR_VECTOR 8'h20

// ************************************
// reset values
// ************************************
`define PIF_RST_CORE_CTRL 8'h00
`define PIF_RST_OPTION 8'hff
`define PIF_RST_FLAGS_ONE 8'h00
`define PIF_RST_FLAGS_TWO 8'h00
`define PIF_RST_ENABLES_ONE 8'h00
`define PIF_RST_ENABLES_TWO 8'h00
`define PIF_RST_MASK 3'h0

// ************************************
// core control and capcomp two field positions
// ************************************
`define PIF_BIT_GLOBAL_EN 7
`define PIF_BIT_PERIPH_EN 6
`define PIF_CORE_EN_HI 5
`define PIF_CORE_EN_LO 3
`define PIF_CORE_FLAG_HI 2
`define PIF_CORE_FLAG_LO 0
`define PIF_BIT_CAPCOMP_TWO 0

// ************************************
// vector, capcomp modes, status bits
// ************************************
`define PIF_VECTOR 13'h0004
`define PIF_MODE_OFF 2'h0
`define PIF_MODE_CAPTURE 2'h1
`define PIF_MODE_COMPARE 2'h2
`define PIF_MODE_PWM 2'h3
`define PIF_ST_REQ_RISE 0
`define PIF_ST_VECTOR 1
`define PIF_ST_CAPCOMP 2

`endif

// [hw/pif_flag_bit.v]
`timescale 1ns/1ps
`include "pif_consts.vh"

// one sticky flag: hardware set wins over software write
module pif_flag_bit (
  input wire ref_clk,
  input wire sys_rst,
  input wire set_in,
  input wire wr_en,
  input wire wr_val,
  output reg flag_q
);
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (set_in) begin
      flag_q <= 1'b1;
    end else if (wr_en) begin
      flag_q <= wr_val;
    end
  end
endmodule // pif_flag_bit

// [hw/pif_sync2.v]
`timescale 1ns/1ps

// two-stage synchroniser for an asynchronous level
module pif_sync2 (
  input wire ref_clk,
  input wire sys_rst,
  input wire async_in,
  output reg sync_q
);
  reg meta_q;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule // pif_sync2

// [verif/pif_irq_ctrl_properties.sv]
`timescale 1ns/1ps
module pif_irq_chk (
  input wire ref_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire irq_accept,
  input wire [12:0] return_pc,
  input wire core_irq_req_q,
  input wire push_return_q,
  input wire [12:0] pushed_pc_q,
  input wire load_vector_q,
  input wire [12:0] vector_pc_q,
  input wire global_irq_enable_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  a_bus_answer: assert property (take |=> wb_ack_o || wb_err_o) else $error("no answer");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
  a_unmapped_err: assert property (take && wb_adr_i > 8'h20 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped not refused");
  a_req_gated: assert property ($rose(core_irq_req_q) |-> $past(global_irq_enable_q))
    else $error("request without enable");
  a_accept_push: assert property (irq_accept && core_irq_req_q && global_irq_enable_q
    |=> push_return_q && load_vector_q) else $error("accept ignored");
  a_push_pc: assert property (push_return_q |-> pushed_pc_q == $past(return_pc))
    else $error("wrong pushed pc");
  a_vector_value: assert property (push_return_q |=> vector_pc_q == 13'h0004)
    else $error("wrong vector");
  a_gie_cleared: assert property (push_return_q |=> !global_irq_enable_q)
    else $error("enable kept");
  a_push_single: assert property (push_return_q |=> !push_return_q) else $error("push held");
  c_push: cover property (push_return_q);
  c_err: cover property (wb_err_o);
  c_req: cover property ($rose(core_irq_req_q));
endmodule // pif_irq_chk

bind pif_irq_ctrl pif_irq_chk u_chk (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .irq_accept, .return_pc, .core_irq_req_q,
  .push_return_q, .pushed_pc_q, .load_vector_q, .vector_pc_q, .global_irq_enable_q);

// [verif/pif_core_model.sv]
`timescale 1ns/1ps
// core side: takes a request after wait_cyc cycles, holds until the push
module pif_core_model (
  input wire ref_clk,
  input wire sys_rst,
  input wire core_irq_req_q,
  input wire push_return_q,
  input wire [3:0] wait_cyc,
  output reg irq_accept,
  output reg [12:0] return_pc
);
  reg [3:0] cnt_q;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_accept <= 1'b0;
      cnt_q <= 4'h0;
      return_pc <= 13'h0123;
    end else if (push_return_q) begin
      irq_accept <= 1'b0;
      cnt_q <= 4'h0;
      return_pc <= return_pc + 13'h0011;
    end else if (core_irq_req_q && !irq_accept) begin
      if (cnt_q == wait_cyc) irq_accept <= 1'b1;
      else cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // pif_core_model

// [verif/peripheral_interrupt_flags_bench.sv]
`timescale 1ns/1ps
module peripheral_interrupt_flags_bench;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, capture_event = 1'b0, err;
  reg compare_event = 1'b0;
  reg [7:0] wb_adr_i = 8'h00, periph_event = 8'h00, q, d, k;
  reg [31:0] wb_dat_i = 32'h0, lfsr = 32'hc4b13df0;
  reg [2:0] core_event = 3'h0;
  reg [1:0] capcomp_two_mode = 2'h0;
  reg [3:0] lat = 4'h0;
  integer failures = 0, tests_run = 0, i, n;
  wire [31:0] wb_dat_o;
  wire [12:0] return_pc;
  wire [7:0] option_q;
  wire wb_ack_o, wb_err_o, irq_accept, core_irq_req_q, push_return_q, global_irq_enable_q, irq_q;
  always #5 ref_clk = ~ref_clk;
  pif_irq_ctrl u_dut (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'h1), .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .core_event, .periph_event,
    .capture_event, .compare_event, .capcomp_two_mode, .portb_change_async(1'b0), .irq_accept,
    .return_pc, .core_irq_req_q, .push_return_q, .pushed_pc_q(), .load_vector_q(),
    .vector_pc_q(), .global_irq_enable_q, .option_q, .irq_q);
  pif_core_model u_core (.ref_clk, .sys_rst, .core_irq_req_q, .push_return_q,
    .wait_cyc(lat), .irq_accept, .return_pc);
  function [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ************
  // implemented bits
  // ************
  function [7:0] impl(input [7:0] a);
    impl = (a == 8'h0c || a == 8'h14) ? 8'h01 : 8'hff;
  endfunction
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // called just after a rising edge; leaves one idle cycle
  task wb(input [7:0] a, input w, input [7:0] v);
    begin
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= {24'h0, v};
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      // look just past the edge so the registered answer has settled
      do begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end while (!(wb_ack_o | wb_err_o) && n < 20);
      q = wb_dat_o[7:0];
      err = wb_err_o;
      // request stands through the edge at which ack is sampled high
      @(posedge ref_clk);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
      if (n == 20) begin
        failures = failures + 1;
        end_of_test;
      end
    end
  endtask
  task pulse(input [2:0] c, input [7:0] p, input a, input b);
    begin
      core_event <= c;
      periph_event <= p;
      capture_event <= a;
      compare_event <= b;
      @(posedge ref_clk);
      core_event <= 3'h0;
      periph_event <= 8'h00;
      capture_event <= 1'b0;
      compare_event <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures = failures + 1;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("option", option_q, 8'hff);
    for (i = 0; i < 6; i = i + 1) begin
      wb({i[5:0], 2'b00}, 1'b0, 8'h00);
      chk("reset", q, i == 1 ? 8'hff : 8'h00);
    end
    $display("test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      lfsr = rnd(lfsr);
      k = {i[5:0], 2'b00};
      d = lfsr[7:0] & 8'h7f;
      wb(k, 1'b1, d);
      wb(k, 1'b0, 8'h00);
      chk("rdback", q, d & impl(k));
      if (i == 1) chk("opt_q", option_q, d);
      wb(k, 1'b1, i == 1 ? 8'hff : 8'h00);
    end
    $display("test readback done");
    lfsr = rnd(lfsr);
    pulse(lfsr[10:8], lfsr[7:0], 1'b0, 1'b0);
    wb(8'h08, 1'b0, 8'h00);
    chk("flags1", q, lfsr[7:0]);
    wb(8'h00, 1'b0, 8'h00);
    chk("coreflg", q, {5'h0, lfsr[10:8]});
    chk("noreq", core_irq_req_q, 8'h00);
    wb(8'h08, 1'b1, 8'h00);
    wb(8'h00, 1'b1, 8'h00);
    $display("test events done");
    for (i = 0; i < 4; i = i + 1) begin
      capcomp_two_mode <= i[1:0];
      pulse(3'h0, 8'h00, 1'b1, 1'b0);
      wb(8'h0c, 1'b0, 8'h00);
      chk("capture", q, i == 1 ? 8'h01 : 8'h00);
      wb(8'h0c, 1'b1, 8'h00);
      pulse(3'h0, 8'h00, 1'b0, 1'b1);
      wb(8'h0c, 1'b0, 8'h00);
      chk("compare", q, i == 2 ? 8'h01 : 8'h00);
      wb(8'h0c, 1'b1, 8'h00);
    end
    $display("test capcomp done");
    for (i = 0; i < 2; i = i + 1) begin
      lfsr = rnd(lfsr);
      k = 8'h01 << lfsr[2:0];
      lat <= i ? 4'h7 : 4'h0;
      wb(8'h1c, 1'b1, i ? 8'h00 : 8'h03);
      wb(8'h10, 1'b1, k);
      wb(8'h00, 1'b1, i ? 8'ha0 : 8'hc0);
      pulse(i ? 3'h4 : 3'h0, i ? 8'h00 : k, 1'b0, 1'b0);
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end while (push_return_q !== 1'b1 && n < 40);
      chk("push", push_return_q, 8'h01);
      @(posedge ref_clk);
      wb(8'h20, 1'b0, 8'h00);
      chk("vector", q, 8'h04);
      chk("gie", global_irq_enable_q, 8'h00);
      chk("irq", irq_q, i ? 8'h00 : 8'h01);
      wb(8'h18, 1'b0, 8'h00);
      chk("status", q & 8'h03, 8'h03);
      chk("irqclr", irq_q, 8'h00);
      wb(8'h08, 1'b1, 8'h00);
      wb(8'h00, 1'b1, 8'h00);
    end
    $display("test request done");
    wb(8'h40, 1'b1, 8'h5a);
    chk("unmapped", err, 8'h01);
    $display("test unmapped done");
    end_of_test;
  end
endmodule // peripheral_interrupt_flags_bench
